// *** verilog/fcs_top.sv ***
// Flash command launch, command buffer and status flags
// What this block does
// - Status bits 3, 1 and 0 read zero; writes there do nothing.
// - Writing one to the buffer-empty flag launches the registered command.
// - Buffer-empty clears on a valid launch; it sets again when a burst moves to the array or other work finishes.
// - A command can queue only while a burst program runs; flag one means room, zero means full.
// - Complete flag is set when buffer empty and idle; launch clears it.
// - Software writes to the complete flag are ignored.
// - Program or erase into protected block sets violation, command dropped.
// - Violation flag clears only by writing one to it.
// - Access error on broken sequence, program or erase with undivided clock, or stop while running.
// - Writing one clears the access error; writing zero does nothing.
// - Blank flag sets after blank check only when whole array is erased.
// - Blank flag clears on a valid launch; direct writes ignored.
// - Code 0x05 blank check, 0x40 page erase, 0x41 mass erase.
// - Code 0x20 byte program, 0x25 burst program which may queue.
// - Any other code is illegal and launching it raises access error.
// - A passing blank check sets the security field to unsecured.
// - Without key-write enable, key window writes start a command sequence.
`timescale 1ns/1ns
`default_nettype none
module fcs_top
   import fcs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic arr_wr,
   input wire logic [15:0] arr_addr,
   input wire logic [7:0] arr_wdata,
   input wire logic divider_initialised,
   input wire logic protect_disable,
   input wire logic [6:0] protect_boundary_select,
   input wire logic key_write_enable,
   input wire logic stop_entry,
   input wire logic [1:0] nv_security_code,
   output logic [1:0] security_state_field,
   output logic array_req,
   output logic [7:0] array_cmd,
   output logic [15:0] array_addr,
   output logic [7:0] array_wdata,
   input wire logic array_ack,
   input wire logic array_blank
);
   fcs_seq_t seq_r;
   logic [15:0] seq_addr_r;
   logic [7:0] seq_data_r;
   logic [7:0] seq_cmd_r;
   logic buf_valid_r;
   logic [7:0] buf_cmd_r;
   logic [15:0] buf_addr_r;
   logic [7:0] buf_data_r;
   logic prot_viol_r;
   logic acc_err_r;
   logic blank_r;
   logic sec_loaded_r;
   logic cmd_buffer_empty_flag;
   logic cmd_complete_flag;
   logic st_wr;
   logic cmd_wr;
   logic launch_wr;
   logic key_hit;
   logic seq_arr_wr;
   logic seq_err;
   logic launch_err;
   logic launch_prot;
   logic launch_ok;
   logic launch_take;
   logic stop_err;
   logic ex_start;
   logic ex_busy;
   logic ex_burst;
   logic ex_done;
   logic ex_done_blank;
   logic ex_abort;

   assign st_wr = reg_wr && (reg_addr == FCS_OFF_STATUS);
   assign cmd_wr = reg_wr && (reg_addr == FCS_OFF_CMD);

   // Non-burst work keeps the buffer marked full until the array is finished
   assign cmd_buffer_empty_flag = !buf_valid_r && !(ex_busy && !ex_burst);
   // The done cycle is held out so the blank result has settled when complete reads one
   assign cmd_complete_flag = cmd_buffer_empty_flag && !ex_busy && !ex_done;

   assign launch_wr = st_wr && reg_wdata[FCS_BIT_BUF_EMPTY]
      && cmd_buffer_empty_flag;
   // A launch write only names a command once the sequence reached its last step
   assign launch_take = launch_wr && (seq_r == FCS_SEQ_CMD);

   assign key_hit = (arr_addr >= FCS_KEY_LO) && (arr_addr <= FCS_KEY_HI);
   // Key compare writes belong to the security logic, not to a command
   assign seq_arr_wr = arr_wr && !(key_write_enable && key_hit);

   // Out of order steps break the sequence
   always_comb begin
      seq_err = 1'b0;
      if (seq_arr_wr && (seq_r != FCS_SEQ_IDLE || !cmd_buffer_empty_flag)) begin
         seq_err = 1'b1;
      end
      if (cmd_wr && seq_r != FCS_SEQ_DATA) begin
         seq_err = 1'b1;
      end
      if (launch_wr && seq_r != FCS_SEQ_CMD) begin
         seq_err = 1'b1;
      end
   end

   // Mass erase touches every block, so any protection refuses it
   always_comb begin
      launch_prot = 1'b0;
      if (!protect_disable && fcs_is_modify(seq_cmd_r)) begin
         if (seq_cmd_r == FCS_CMD_MASS_ERASE) begin
            launch_prot = 1'b1;
         end else if (seq_addr_r > {protect_boundary_select, FCS_PROT_LOW_ONES}) begin
            launch_prot = 1'b1;
         end
      end
   end

   assign launch_err = launch_take &&
      (!fcs_is_legal(seq_cmd_r) ||
      (fcs_is_modify(seq_cmd_r) && !divider_initialised));
   assign launch_ok = launch_take && !launch_err && !launch_prot;
   assign stop_err = stop_entry && ex_busy;
   assign ex_abort = stop_err;

   // Command sequence tracker
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         seq_r <= FCS_SEQ_IDLE;
      end else if (seq_err || launch_wr) begin
         seq_r <= FCS_SEQ_IDLE;
      end else begin
         unique case (seq_r)
            FCS_SEQ_IDLE: begin
               if (seq_arr_wr) begin
                  seq_r <= FCS_SEQ_DATA;
               end
            end
            FCS_SEQ_DATA: begin
               if (cmd_wr) begin
                  seq_r <= FCS_SEQ_CMD;
               end
            end
            FCS_SEQ_CMD: begin
               seq_r <= FCS_SEQ_CMD;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         seq_addr_r <= 16'h0000;
      end else if (seq_arr_wr && seq_r == FCS_SEQ_IDLE) begin
         seq_addr_r <= arr_addr;
      end
   end

   // Data is kept for every command and is sent on to the array with each of them
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         seq_data_r <= 8'h00;
      end else if (seq_arr_wr && seq_r == FCS_SEQ_IDLE) begin
         seq_data_r <= arr_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         seq_cmd_r <= FCS_CMD_RESET;
      end else if (cmd_wr && seq_r == FCS_SEQ_DATA) begin
         seq_cmd_r <= reg_wdata;
      end
   end

   // One-entry command buffer; a queued burst waits for the executor
   assign ex_start = buf_valid_r && !ex_busy;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         buf_valid_r <= 1'b0;
      end else if (stop_err) begin
         buf_valid_r <= 1'b0;
      end else if (launch_ok) begin
         buf_valid_r <= 1'b1;
      end else if (ex_start) begin
         buf_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         buf_cmd_r <= FCS_CMD_RESET;
         buf_addr_r <= 16'h0000;
         buf_data_r <= 8'h00;
      end else if (launch_ok) begin
         buf_cmd_r <= seq_cmd_r;
         buf_addr_r <= seq_addr_r;
         buf_data_r <= seq_data_r;
      end
   end

   // Error flags: a new event in the clearing cycle wins
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prot_viol_r <= 1'b0;
      end else if (launch_take && !launch_err && launch_prot) begin
         prot_viol_r <= 1'b1;
      end else if (st_wr && reg_wdata[FCS_BIT_PROT_VIOL]) begin
         prot_viol_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         acc_err_r <= 1'b0;
      end else if (seq_err || launch_err || stop_err) begin
         acc_err_r <= 1'b1;
      end else if (st_wr && reg_wdata[FCS_BIT_ACC_ERR]) begin
         acc_err_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         blank_r <= 1'b0;
      end else if (launch_ok) begin
         blank_r <= 1'b0;
      end else if (ex_done_blank) begin
         blank_r <= 1'b1;
      end
   end

   // Security state is loaded from the stored code once reset has gone
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sec_loaded_r <= 1'b0;
      end else begin
         sec_loaded_r <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         security_state_field <= FCS_SEC_RESET;
      end else if (ex_done_blank) begin
         security_state_field <= FCS_SEC_UNSECURED;
      end else if (!sec_loaded_r) begin
         security_state_field <= nv_security_code;
      end
   end

   // Reserved positions stay low by construction, whatever the flags do
   function automatic logic [7:0] status_word(input logic bef, input logic ccf, input logic pv,
         input logic ae, input logic bl);
      status_word = 8'h00;
      status_word[FCS_BIT_BUF_EMPTY] = bef;
      status_word[FCS_BIT_COMPLETE] = ccf;
      status_word[FCS_BIT_PROT_VIOL] = pv;
      status_word[FCS_BIT_ACC_ERR] = ae;
      status_word[FCS_BIT_BLANK] = bl;
   endfunction

   // Read data; the command register has no read path
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd && reg_addr == FCS_OFF_STATUS) begin
         reg_rdata <= status_word(cmd_buffer_empty_flag, cmd_complete_flag,
            prot_viol_r, acc_err_r, blank_r);
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   fcs_exec u_exec (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .start(ex_start),
      .start_cmd(buf_cmd_r),
      .start_addr(buf_addr_r),
      .start_data(buf_data_r),
      .abort(ex_abort),
      .busy(ex_busy),
      .run_is_burst(ex_burst),
      .done(ex_done),
      .done_blank(ex_done_blank),
      .array_req(array_req),
      .array_cmd(array_cmd),
      .array_addr(array_addr),
      .array_wdata(array_wdata),
      .array_ack(array_ack),
      .array_blank(array_blank)
   );
endmodule
`default_nettype wire

// *** verilog/fcs_pkg.sv ***
// Constants shared by the flash command and status block
package fcs_pkg;
   // Register offsets on the plain register port
   localparam logic [7:0] FCS_OFF_STATUS = 8'h00;
   localparam logic [7:0] FCS_OFF_CMD = 8'h01;
   // Status field positions
   localparam int FCS_BIT_BUF_EMPTY = 7;
   localparam int FCS_BIT_COMPLETE = 6;
   localparam int FCS_BIT_PROT_VIOL = 5;
   localparam int FCS_BIT_ACC_ERR = 4;
   localparam int FCS_BIT_BLANK = 2;
   // Command codes
   localparam logic [7:0] FCS_CMD_BLANK = 8'h05;
   localparam logic [7:0] FCS_CMD_BYTE_PROG = 8'h20;
   localparam logic [7:0] FCS_CMD_BURST_PROG = 8'h25;
   localparam logic [7:0] FCS_CMD_PAGE_ERASE = 8'h40;
   localparam logic [7:0] FCS_CMD_MASS_ERASE = 8'h41;
   localparam logic [7:0] FCS_CMD_RESET = 8'h00;
   // Security encodings
   localparam logic [1:0] FCS_SEC_UNSECURED = 2'h2;
   localparam logic [1:0] FCS_SEC_RESET = 2'h3;
   // Backdoor key address window
   localparam logic [15:0] FCS_KEY_LO = 16'hffb0;
   localparam logic [15:0] FCS_KEY_HI = 16'hffb7;
   // Low address bits covered by one protect boundary step
   localparam logic [8:0] FCS_PROT_LOW_ONES = 9'h1ff;

   typedef enum logic [2:0] {
      FCS_SEQ_IDLE = 3'b001,
      FCS_SEQ_DATA = 3'b010,
      FCS_SEQ_CMD = 3'b100
   } fcs_seq_t;

   typedef enum logic [1:0] {
      FCS_EX_IDLE = 2'b01,
      FCS_EX_RUN = 2'b10
   } fcs_ex_t;

   function automatic logic fcs_is_legal(input logic [7:0] c);
      return (c == FCS_CMD_BLANK) || (c == FCS_CMD_BYTE_PROG) ||
         (c == FCS_CMD_BURST_PROG) || (c == FCS_CMD_PAGE_ERASE) ||
         (c == FCS_CMD_MASS_ERASE);
   endfunction

   function automatic logic fcs_is_modify(input logic [7:0] c);
      return (c == FCS_CMD_BYTE_PROG) || (c == FCS_CMD_BURST_PROG) ||
         (c == FCS_CMD_PAGE_ERASE) || (c == FCS_CMD_MASS_ERASE);
   endfunction
endpackage

// *** verilog/fcs_exec.sv ***
// Executes one command against the flash array with a request/acknowledge handshake
`timescale 1ns/1ns
`default_nettype none
module fcs_exec
   import fcs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [7:0] start_cmd,
   input wire logic [15:0] start_addr,
   input wire logic [7:0] start_data,
   input wire logic abort,
   output logic busy,
   output logic run_is_burst,
   output logic done,
   output logic done_blank,
   output logic array_req,
   output logic [7:0] array_cmd,
   output logic [15:0] array_addr,
   output logic [7:0] array_wdata,
   input wire logic array_ack,
   input wire logic array_blank
);
   fcs_ex_t state_r;

   assign busy = (state_r == FCS_EX_RUN);
   assign array_req = busy;
   assign run_is_burst = busy && (array_cmd == FCS_CMD_BURST_PROG);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= FCS_EX_IDLE;
      end else begin
         unique case (state_r)
            FCS_EX_IDLE: begin
               if (start) begin
                  state_r <= FCS_EX_RUN;
               end
            end
            FCS_EX_RUN: begin
               if (abort || array_ack) begin
                  state_r <= FCS_EX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         array_cmd <= FCS_CMD_RESET;
         array_addr <= 16'h0000;
         array_wdata <= 8'h00;
      end else if (start && !busy) begin
         array_cmd <= start_cmd;
         array_addr <= start_addr;
         array_wdata <= start_data;
      end
   end

   // Blank result is sampled with the acknowledge, so it needs no hold by the array
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         done <= 1'b0;
         done_blank <= 1'b0;
      end else begin
         done <= busy && array_ack && !abort;
         done_blank <= busy && array_ack && !abort && array_blank &&
            (array_cmd == FCS_CMD_BLANK);
      end
   end
endmodule
`default_nettype wire

// *** sim/fcs_array_model.sv ***
// Behavioural flash array answering each request after a set delay
`timescale 1ns/1ns
`default_nettype none
module fcs_array_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic array_req,
   input wire logic [3:0] wait_cycles,
   input wire logic blank_res,
   output logic array_ack,
   output logic array_blank
);
   logic [3:0] cnt_r;
   logic tog_r;
   // Result is only valid beside ack; elsewhere it wanders so nothing leans on it
   assign array_blank = array_ack ? blank_res : tog_r;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 4'h0;
         array_ack <= 1'b0;
         tog_r <= 1'b0;
      end else begin
         tog_r <= ~tog_r;
         array_ack <= 1'b0;
         if (!array_req || array_ack) begin
            cnt_r <= 4'h0;
         end else if (cnt_r == wait_cycles) begin
            array_ack <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/fcs_top_assertions.sv ***
// Port-level checker for the flash command and status block
`timescale 1ns/1ns
`default_nettype none
module fcs_top_chk
   import fcs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic divider_initialised,
   input wire logic protect_disable,
   input wire logic [6:0] protect_boundary_select,
   input wire logic stop_entry,
   input wire logic array_req,
   input wire logic [7:0] array_cmd,
   input wire logic [15:0] array_addr,
   input wire logic array_ack,
   input wire logic array_blank
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   a_rsvd_bits_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |->
      reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'h0) else $error("reserved bit set");
   a_cmd_reads_zero: assert property ($past(reg_rd) && $past(reg_addr) != 8'h00 |->
      reg_rdata == 8'h00) else $error("command read not zero");
   a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside slot");
   a_done_means_idle: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00
      && reg_rdata[6] |-> reg_rdata[7] && !$past(array_req)) else $error("complete while busy");
   a_req_held: assert property (array_req && !array_ack && !stop_entry |=> array_req
      && $stable(array_cmd) && $stable(array_addr)) else $error("request not held");
   a_stop_aborts: assert property (array_req && !array_ack && stop_entry |=> !array_req)
      else $error("stop did not abort");
   a_legal_only: assert property (array_req |-> array_cmd inside {8'h05, 8'h20, 8'h25,
      8'h40, 8'h41}) else $error("illegal code reached array");
   a_prot_honoured: assert property (array_req && array_cmd != 8'h05 && !protect_disable
      |-> array_cmd != 8'h41 && array_addr <= {protect_boundary_select, 9'h1ff})
      else $error("protected target reached array");
   a_divider_needed: assert property (array_req && array_cmd != 8'h05
      |-> divider_initialised) else $error("modify without divider");
   c_stop: cover property (array_req && stop_entry);
   c_blank_pass: cover property (array_ack && array_blank && array_cmd == 8'h05);
   c_burst_chain: cover property (array_ack ##2 array_req);
endmodule
bind fcs_top fcs_top_chk u_fcs_top_chk(.ref_clk, .nrst, .reg_addr, .reg_rd, .reg_rdata,
   .divider_initialised, .protect_disable, .protect_boundary_select, .stop_entry,
   .array_req, .array_cmd, .array_addr, .array_ack, .array_blank);
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the flash command and status block
`timescale 1ns/1ns
`default_nettype none
module tb;
   import fcs_pkg::*;
   logic ref_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, arr_wr = 0;
   logic div = 1, poff = 0, key = 0, stop = 0, bres = 0, req_q = 0, ack_q = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, arr_wdata = 0, reg_rdata, array_cmd, array_wdata, s;
   logic [15:0] arr_addr = 0, array_addr;
   logic [6:0] psel = 7'h10;
   logic [3:0] wt = 0;
   logic [1:0] sec;
   logic array_req, array_ack, array_blank;
   logic [31:0] cap;
   logic [47:0] cmds = 48'h052025404105;
   int num_errors = 0, n_checks = 0;
   always #2 ref_clk = ~ref_clk;
   fcs_top u_fcs_top(.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .arr_wr, .arr_addr, .arr_wdata, .divider_initialised(div), .protect_disable(poff),
      .protect_boundary_select(psel), .key_write_enable(key), .stop_entry(stop),
      .nv_security_code(2'h0), .security_state_field(sec), .array_req, .array_cmd,
      .array_addr, .array_wdata, .array_ack, .array_blank);
   fcs_array_model u_fcs_array_model(.ref_clk, .nrst, .array_req, .wait_cycles(wt),
      .blank_res(bres), .array_ack, .array_blank);
   // Catch each command as the array takes it, including a chained burst
   always @(posedge ref_clk) begin
      if (array_req && (!req_q || ack_q))
         cap <= {array_cmd, array_addr, array_wdata};
      req_q <= array_req;
      ack_q <= array_ack;
   end
   task automatic summarize;
      if (num_errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] ex(input logic pv, input logic ae, input logic b);
      return {2'b11, pv, ae, 1'b0, b, 2'b00};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge ref_clk);
      reg_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge ref_clk);
      reg_rd <= 0;
      #1 d = reg_rdata;
   endtask
   task automatic st(input logic [7:0] e);
      rd(FCS_OFF_STATUS, s);
      chk(s, e);
   endtask
   task automatic aw(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      arr_addr <= a;
      arr_wdata <= d;
      arr_wr <= 1;
      @(posedge ref_clk);
      arr_wr <= 0;
   endtask
   task automatic run(input logic w, input logic [7:0] c, input logic [15:0] a,
         input logic [7:0] d);
      if (w) aw(a, d);
      wr(FCS_OFF_CMD, c);
      wr(FCS_OFF_STATUS, 8'h80);
   endtask
   // Polls instead of waiting a fixed time, since the array delay varies
   task automatic wdone;
      for (int i = 0; i < 40; i++) begin
         rd(FCS_OFF_STATUS, s);
         if (s[6] === 1'b1) break;
      end
      chk(s[6], 1'b1);
   endtask
   task automatic bad(input logic w, input logic [7:0] c, input logic [15:0] a,
         input logic [7:0] e);
      run(w, c, a, 8'h5a);
      st(e);
      wr(FCS_OFF_STATUS, 8'h30);
      st(ex(0, 0, 0));
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      num_errors++;
      summarize();
   end
   initial begin
      logic [7:0] c, d;
      logic [15:0] a;
      int k;
      void'($urandom(10343));
      repeat (16) @(posedge ref_clk);
      nrst <= 1;
      st(ex(0, 0, 0));
      chk(sec, 0);
      rd(FCS_OFF_CMD, s);
      chk(s, 0);
      wr(FCS_OFF_STATUS, 8'h4f);
      st(ex(0, 0, 0));
      for (k = 0; k < 6; k++) begin
         c = cmds[47 - 8 * k -: 8];
         a = (k == 1) ? 16'h21ff : 16'($urandom_range(16'h21ff));
         d = 8'($urandom);
         poff <= (c == 8'h41);
         bres <= (k == 5) | 1'($urandom);
         wt <= 4'($urandom);
         run(1, c, a, d);
         wdone();
         chk(cap, {c, a, d});
         st(ex(0, 0, c == 8'h05 && bres));
      end
      chk(sec, FCS_SEC_UNSECURED);
      run(1, 8'h20, 16'h0030, 8'h33);
      wdone();
      chk(cap, 32'h20003033);
      st(ex(0, 0, 0));
      run(1, 8'h20, 16'h2200, 8'h00);
      st(ex(1, 0, 0));
      wr(FCS_OFF_STATUS, 8'h10);
      st(ex(1, 0, 0));
      wr(FCS_OFF_STATUS, 8'h20);
      st(ex(0, 0, 0));
      bad(1, 8'h41, 16'h0000, ex(1, 0, 0));
      div <= 0;
      bad(1, 8'h40, 16'h0200, ex(0, 1, 0));
      div <= 1;
      bad(0, 8'h20, 16'h0000, ex(0, 1, 0));
      key <= 1;
      bad(1, 8'h20, 16'hffb2, ex(0, 1, 0));
      key <= 0;
      for (k = 0; k < 5; k++) begin
         do c = 8'($urandom); while (c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41});
         bad(1, (k == 0) ? 8'hff : c, 16'h0100, ex(0, 1, 0));
      end
      run(0, 8'h20, 16'h0000, 8'h00);
      wr(FCS_OFF_STATUS, 8'h00);
      st(ex(0, 1, 0));
      wr(FCS_OFF_STATUS, 8'h10);
      st(ex(0, 0, 0));
      wt <= 4'hf;
      run(1, 8'h20, 16'h0010, 8'h11);
      wr(FCS_OFF_STATUS, 8'h44);
      st(8'h00);
      @(posedge ref_clk) stop <= 1;
      @(posedge ref_clk) stop <= 0;
      st(ex(0, 1, 0));
      wr(FCS_OFF_STATUS, 8'h10);
      run(1, 8'h25, 16'h0020, 8'h01);
      repeat (2) @(posedge ref_clk);
      st(8'h80);
      run(1, 8'h25, 16'h0021, 8'h02);
      st(8'h00);
      wdone();
      chk(cap, 32'h25002102);
      st(ex(0, 0, 0));
      summarize();
   end
endmodule
`default_nettype wire
